// ### lhb_cfg.svh
// Constants of the display controller host bus link
`ifndef LHB_CFG_SVH
`define LHB_CFG_SVH
// Two-wire slave address, arbitrary value
`define LHB_I2C_ADDR    7'h3a
// Function-set instruction: code in bits 7:5, bus width flag in bit 4
`define LHB_FSET_CODE   3'h1
`define LHB_FSET_DL     4
// Control byte: select bit position
`define LHB_CTRL_SEL    6
// Reset value of the parallel four-bit mode flag
`define LHB_NIB_RST     1'h0
// Synchroniser bundle positions on the device side
`define LHB_SY_E        12
`define LHB_SY_RS       11
`define LHB_SY_RW       10
`define LHB_SY_SCL      9
`define LHB_SY_SDA      8
// Host timing: clk cycles per bus phase, clk cycles per link clock half
// Phase must outlast the device's two-flop sync plus answer latency
`define LHB_PHASE_CYC   4'hc
`define LHB_LINK_HALF   4'h1
`endif

// ### lhb_pkg.sv
// Types of the display controller host bus link
package lhb_pkg;
    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_WR   = 3'b010,
        I_RD   = 3'b011,
        I_WAIT = 3'b100
    } lhb_i2c_type;

    typedef enum logic [3:0] {
        H_IDLE  = 4'b0000,
        H_PSET  = 4'b0001,
        H_PHIGH = 4'b0010,
        H_PLOW  = 4'b0011,
        H_START = 4'b0100,
        H_SLO   = 4'b0101,
        H_SDAT  = 4'b0110,
        H_SHI   = 4'b0111,
        H_SP1   = 4'b1000,
        H_SP2   = 4'b1001,
        H_SP3   = 4'b1010
    } lhb_host_st_type;

    typedef struct packed {
        logic [12:0] s1; logic [12:0] s2;
        logic        e_d; logic scl_d; logic sda_d;
        logic        nib; logic half; logic [3:0] hi;
        logic        rx_valid; logic [7:0] rx_byte; logic rx_sel; logic rd_done;
        logic [7:0]  db_o; logic [7:0] db_oe;
        lhb_i2c_type ist; logic [3:0] bits; logic [7:0] sh;
        logic        sda_oe; logic rw; logic sel; logic ctrl; logic ack;
    } lhb_dev_type;

    typedef struct packed {
        lhb_host_st_type st; logic [3:0] cnt; logic [3:0] div; logic lclk;
        logic        e; logic rs; logic rw; logic [7:0] db_o; logic [7:0] db_oe;
        logic        scl_oe; logic sda_oe; logic half; logic nib; logic ser;
        logic [3:0]  bits; logic [1:0] idx; logic [7:0] sh; logic [7:0] wd;
        logic [7:0]  rdata; logic done; logic ready; logic nak;
        logic [8:0]  s1; logic [8:0] s2;
    } lhb_host_type;
endpackage

// ### lhb_if.sv
// Pins between host controller and display controller
`timescale 1ns/1ps
interface lhb_if;
    logic       link_clk;
    logic       e;
    logic       rs;
    logic       rw;
    logic [7:0] host_db_o;
    logic [7:0] host_db_oe;
    logic [7:0] dev_db_o;
    logic [7:0] dev_db_oe;
    logic [7:0] db;
    logic       host_scl_o;
    logic       host_scl_oe;
    logic       host_sda_o;
    logic       host_sda_oe;
    logic       dev_sda_o;
    logic       dev_sda_oe;
    logic       scl;
    logic       sda;

    // Data pins float high when nobody drives them
    assign db  = (host_db_o & host_db_oe) | (dev_db_o & dev_db_oe) | ~(host_db_oe | dev_db_oe);
    // Open-drain two-wire lines with pull-ups
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev (input link_clk, e, rs, rw, db, scl, sda,
                 output dev_db_o, dev_db_oe, dev_sda_o, dev_sda_oe);
    modport host (output link_clk, e, rs, rw, host_db_o, host_db_oe,
                  output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                  input db, scl, sda);
endinterface

// ### lhb_device.sv
// Display controller end: parallel and two-wire host ports
`timescale 1ns/1ps
`include "lhb_cfg.svh"
// Notes on behaviour
// - Byte mode: eight bits per strobe
// - Nibble mode: two strobes on upper pins
// - Upper nibble first; byte done after second
// - Status read also takes two nibble strobes
// - Bus width set by function-set instruction
// - Host leaves lower pins open in nibble mode
// - Master starts only on idle bus
// - Addressed slave acknowledges every received byte
// - Ninth clock: transmitter releases data line
// - Master acknowledges read bytes except last
// - Acknowledger holds data low through clock high
// - No acknowledge ends read; slave releases line
// - First byte after start is address
// - Device never holds serial clock low
module lhb_device
    import lhb_pkg::*;
(
    lhb_if.dev         bus,          // Link pins, clocked by link_clk
    input  wire logic  rst_n,        // Async reset, active low
    input  wire logic [7:0] status_byte, // Busy flag and address counter
    input  wire logic [7:0] read_byte,   // Display data for reads
    output logic       rx_valid,     // Received byte, one-cycle pulse
    output logic [7:0] rx_byte,      // Received byte value
    output logic       rx_sel,       // Received byte is display data
    output logic       rd_done,      // Read byte taken, one-cycle pulse
    output logic       nibble_mode   // Parallel bus in four-bit mode
);
    lhb_dev_type q;
    lhb_dev_type n;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic       e;
        logic       rs;
        logic       rw;
        logic       scl;
        logic       sda;
        logic [7:0] db;
        logic [7:0] psel;
        logic [7:0] ssel;
        logic       got;
        logic [7:0] gv;
        logic       gs;
        n        = q;
        got      = 1'h0;
        gv       = 8'h00;
        gs       = 1'h0;
        // Pins pass two flops before use
        n.s1     = {bus.e, bus.rs, bus.rw, bus.scl, bus.sda, bus.db};
        n.s2     = q.s1;
        e        = q.s2[`LHB_SY_E];
        rs       = q.s2[`LHB_SY_RS];
        rw       = q.s2[`LHB_SY_RW];
        scl      = q.s2[`LHB_SY_SCL];
        sda      = q.s2[`LHB_SY_SDA];
        db       = q.s2[7:0];
        n.e_d    = e;
        n.scl_d  = scl;
        n.sda_d  = sda;
        n.rx_valid = 1'h0;
        n.rd_done  = 1'h0;
        psel     = rs ? read_byte : status_byte;
        ssel     = q.sel ? read_byte : status_byte;

        // Parallel read: drive on strobe rise
        if (e && !q.e_d && rw) begin
            if (q.nib) begin
                n.db_oe = 8'hf0;
                n.db_o  = {q.half ? psel[3:0] : psel[7:4], 4'hf};
            end else begin
                n.db_oe = 8'hff;
                n.db_o  = psel;
            end
        end
        // Strobe fall ends each cycle
        if (!e && q.e_d) begin
            n.db_oe = 8'h00;
            if (rw) begin
                if (!q.nib || q.half) begin
                    n.rd_done = 1'h1;
                end
                n.half = q.nib & ~q.half;
            end else if (q.nib && !q.half) begin
                n.hi   = db[7:4];
                n.half = 1'h1;
            end else begin
                // Lower pins ignored in nibble mode
                got    = 1'h1;
                gv     = q.nib ? {q.hi, db[7:4]} : db;
                gs     = rs;
                n.half = 1'h0;
            end
        end

        // Two-wire slave; no clock output exists at all
        if (scl && q.scl_d && q.sda_d && !sda) begin
            n.ist    = I_ADDR;
            n.bits   = 4'h0;
            n.ack    = 1'h0;
            n.sda_oe = 1'h0;
            n.ctrl   = 1'h0;
            n.sh     = 8'h00;
        end else if (scl && q.scl_d && !q.sda_d && sda) begin
            n.ist    = I_IDLE;
            n.ack    = 1'h0;
            n.sda_oe = 1'h0;
        end else begin
            case (q.ist)
                I_ADDR, I_WR: begin
                    if (scl && !q.scl_d && q.bits < 4'h8) begin
                        n.sh   = {q.sh[6:0], sda};
                        n.bits = q.bits + 4'h1;
                    end else if (!scl && q.scl_d && q.ack) begin
                        // End of acknowledge pulse
                        n.ack    = 1'h0;
                        n.bits   = 4'h0;
                        n.sda_oe = 1'h0;
                        if (q.ist == I_ADDR && q.rw) begin
                            n.ist    = I_RD;
                            n.sh     = ssel;
                            n.sda_oe = ~ssel[7];
                        end else begin
                            n.ist = I_WR;
                        end
                    end else if (!scl && q.scl_d && q.bits == 4'h8) begin
                        if (q.ist == I_ADDR && q.sh[7:1] != `LHB_I2C_ADDR) begin
                            n.ist = I_WAIT;
                        end else begin
                            // Pull low across the ninth clock
                            n.sda_oe = 1'h1;
                            n.ack    = 1'h1;
                            if (q.ist == I_ADDR) begin
                                n.rw = q.sh[0];
                            end else if (!q.ctrl) begin
                                n.ctrl = 1'h1;
                                n.sel  = q.sh[`LHB_CTRL_SEL];
                            end else begin
                                got = 1'h1;
                                gv  = q.sh;
                                gs  = q.sel;
                            end
                        end
                    end
                end
                I_RD: begin
                    if (scl && !q.scl_d && q.bits < 4'h8) begin
                        n.bits = q.bits + 4'h1;
                    end else if (scl && !q.scl_d && q.bits == 4'h8) begin
                        n.rd_done = 1'h1;
                        if (!sda) begin
                            n.ack = 1'h1;
                        end else begin
                            n.ist = I_WAIT;
                        end
                    end else if (!scl && q.scl_d && q.ack) begin
                        n.ack    = 1'h0;
                        n.bits   = 4'h0;
                        n.sh     = ssel;
                        n.sda_oe = ~ssel[7];
                    end else if (!scl && q.scl_d && q.bits < 4'h8) begin
                        n.sda_oe = ~q.sh[6];
                        n.sh     = {q.sh[6:0], 1'h0};
                    end else if (!scl && q.scl_d) begin
                        n.sda_oe = 1'h0;
                    end
                end
                I_WAIT: begin
                    n.sda_oe = 1'h0;
                end
                default: begin
                    n.sda_oe = 1'h0;
                end
            endcase
        end

        // Deliver a byte; function set picks the bus width
        if (got) begin
            n.rx_valid = 1'h1;
            n.rx_byte  = gv;
            n.rx_sel   = gs;
            if (!gs && gv[7:5] == `LHB_FSET_CODE) begin
                n.nib  = ~gv[`LHB_FSET_DL];
                n.half = 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge bus.link_clk or negedge rst_n) begin
        if (!rst_n) begin
            q     <= '0;
            q.nib <= `LHB_NIB_RST;
            q.ist <= I_IDLE;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus.dev_db_o   = q.db_o;
    assign bus.dev_db_oe  = q.db_oe;
    assign bus.dev_sda_o  = 1'h0;
    assign bus.dev_sda_oe = q.sda_oe;
    assign rx_valid       = q.rx_valid;
    assign rx_byte        = q.rx_byte;
    assign rx_sel         = q.rx_sel;
    assign rd_done        = q.rd_done;
    assign nibble_mode    = q.nib;
endmodule

// ### lhb_host.sv
// Host controller end: drives parallel and two-wire transfers
`timescale 1ns/1ps
`include "lhb_cfg.svh"
module lhb_host
    import lhb_pkg::*;
(
    input  wire logic  clk,      // System clock
    input  wire logic  rst_n,    // Async reset, active low
    lhb_if.host        bus,      // Link pins
    input  wire logic  req,      // Start a transfer
    input  wire logic  ser,      // 1 = two-wire port, 0 = parallel
    input  wire logic  rd,       // 1 = read
    input  wire logic  sel,      // 1 = display data, 0 = instruction
    input  wire logic  nib,      // Parallel bus is in four-bit mode
    input  wire logic [7:0] wdata, // Byte to write
    output logic       ready,    // Idle, request may be made
    output logic       done,     // Transfer over, one-cycle pulse
    output logic [7:0] rdata,    // Byte read
    output logic       nak       // Last transfer was serial and not acknowledged
);
    lhb_host_type q;
    lhb_host_type n;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic       tick;
        logic       sda;
        logic [7:0] db;
        logic       rx;
        n      = q;
        n.s1   = {bus.sda, bus.db};
        n.s2   = q.s1;
        sda    = q.s2[8];
        db     = q.s2[7:0];
        n.done = 1'h0;
        tick   = (q.cnt == 4'h0);
        rx     = q.rw && q.idx == 2'h1;
        n.cnt  = tick ? `LHB_PHASE_CYC - 4'h1 : q.cnt - 4'h1;
        // Link clock divider
        if (q.div == `LHB_LINK_HALF - 4'h1) begin
            n.div  = 4'h0;
            n.lclk = ~q.lclk;
        end else begin
            n.div  = q.div + 4'h1;
        end
        case (q.st)
            H_IDLE: begin
                n.cnt = `LHB_PHASE_CYC - 4'h1;
                if (req) begin
                    n.ready = 1'h0;
                    n.nak   = 1'h0;
                    n.ser   = ser;
                    n.rw    = rd;
                    n.wd    = wdata;
                    n.nib   = nib;
                    n.half  = 1'h0;
                    n.idx   = 2'h0;
                    n.bits  = 4'h0;
                    if (ser) begin
                        // Start only from the idle bus
                        n.st     = H_START;
                        n.sda_oe = 1'h1;
                        n.sh     = {`LHB_I2C_ADDR, rd};
                    end else begin
                        n.st    = H_PSET;
                        n.rs    = sel;
                        n.db_oe = rd ? 8'h00 : (nib ? 8'hf0 : 8'hff);
                        n.db_o  = nib ? {wdata[7:4], 4'hf} : wdata;
                    end
                end
            end
            H_PSET: if (tick) begin
                n.e  = 1'h1;
                n.st = H_PHIGH;
            end
            H_PHIGH: if (tick) begin
                if (q.rw && q.nib && q.half) begin
                    n.rdata[3:0] = db[7:4];
                end else if (q.rw && q.nib) begin
                    n.rdata[7:4] = db[7:4];
                end else if (q.rw) begin
                    n.rdata = db;
                end
                n.e  = 1'h0;
                n.st = H_PLOW;
            end
            H_PLOW: if (tick) begin
                if (q.nib && !q.half) begin
                    // Second nibble, also for status reads
                    n.half = 1'h1;
                    n.db_o = {q.wd[3:0], 4'hf};
                    n.st   = H_PSET;
                end else begin
                    n.db_oe = 8'h00;
                    n.done  = 1'h1;
                    n.ready = 1'h1;
                    n.st    = H_IDLE;
                end
            end
            H_START: if (tick) begin
                n.scl_oe = 1'h1;
                n.st     = H_SLO;
            end
            H_SLO: if (tick) begin
                // Data changes only while the clock is low
                n.sda_oe = (q.bits < 4'h8 && !rx) ? ~q.sh[7] : 1'h0;
                n.st     = H_SDAT;
            end
            H_SDAT: if (tick) begin
                n.scl_oe = 1'h0;
                n.st     = H_SHI;
            end
            H_SHI: if (tick) begin
                n.scl_oe = 1'h1;
                n.st     = H_SLO;
                if (q.bits < 4'h8) begin
                    n.sh   = {q.sh[6:0], sda};
                    n.bits = q.bits + 4'h1;
                end else if (rx) begin
                    // Single byte read: no acknowledge ends it
                    n.rdata = q.sh;
                    n.st    = H_SP1;
                end else if (sda || q.idx == 2'h2) begin
                    n.nak = sda;
                    n.st  = H_SP1;
                end else begin
                    n.idx  = q.idx + 2'h1;
                    n.bits = 4'h0;
                    n.sh   = (q.idx == 2'h0) ? {1'h0, q.rs, 6'h00} : q.wd;
                    if (q.idx == 2'h0) begin
                        n.sh[`LHB_CTRL_SEL] = q.rs;
                    end
                end
            end
            H_SP1: if (tick) begin
                n.sda_oe = 1'h1;
                n.st     = H_SP2;
            end
            H_SP2: if (tick) begin
                n.scl_oe = 1'h0;
                n.st     = H_SP3;
            end
            H_SP3: if (tick) begin
                n.sda_oe = 1'h0;
                n.done   = 1'h1;
                n.ready  = 1'h1;
                n.st     = H_IDLE;
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
        if (q.st == H_IDLE && req && !ser) begin
            n.rs = sel;
        end else if (q.st == H_IDLE && req) begin
            n.rs = sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q       <= '0;
            q.st    <= H_IDLE;
            q.ready <= 1'h1;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus.link_clk    = q.lclk;
    assign bus.e           = q.e;
    assign bus.rs          = q.rs;
    assign bus.rw          = q.rw;
    assign bus.host_db_o   = q.db_o;
    assign bus.host_db_oe  = q.db_oe;
    assign bus.host_scl_o  = 1'h0;
    assign bus.host_scl_oe = q.scl_oe;
    assign bus.host_sda_o  = 1'h0;
    assign bus.host_sda_oe = q.sda_oe;
    assign ready           = q.ready;
    assign done            = q.done;
    assign rdata           = q.rdata;
    assign nak             = q.nak;
endmodule

// ### lhb_link_properties.sv
// Pin-level checks on the link between host and display controller ends
`timescale 1ns/1ps
`include "lhb_cfg.svh"
module lhb_link_properties (
    input wire logic       clk,         // Host clock
    input wire logic       rst_n,       // Reset, active low
    input wire logic       e,           // Parallel strobe
    input wire logic       rs,          // Select line
    input wire logic       rw,          // Direction line
    input wire logic [7:0] host_db_o,   // Host data drive
    input wire logic [7:0] host_db_oe,  // Host data enable
    input wire logic [7:0] dev_db_oe,   // Device data enable
    input wire logic       host_scl_oe, // Host clock pull
    input wire logic       dev_sda_oe,  // Device data pull
    input wire logic       scl,         // Serial clock
    input wire logic       sda          // Serial data
);
    logic       scl_ff;
    logic       sda_ff;
    logic       rw_ff;
    logic       far_ff;
    logic [3:0] bit_ff;
    logic [3:0] byte_ff;
    logic [6:0] sh_ff;
    wire        rise    = scl && !scl_ff;
    wire        fall    = !scl && scl_ff;
    wire        frame_c = scl && scl_ff && (sda != sda_ff);
    wire        ack_end = fall && (bit_ff == 4'h9);

    ////////////////////////////////////////////////////////////////////////
    // Bit and byte tracking within a serial frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_ff  <= 1'b1;
            sda_ff  <= 1'b1;
            rw_ff   <= 1'b0;
            far_ff  <= 1'b0;
            bit_ff  <= 4'h0;
            byte_ff <= 4'h0;
            sh_ff   <= 7'h00;
        end else begin
            scl_ff <= scl;
            sda_ff <= sda;
            if (frame_c) begin
                bit_ff  <= 4'h0;
                byte_ff <= 4'h0;
                far_ff  <= 1'b0;
            end else if (rise) begin
                sh_ff  <= {sh_ff[5:0], sda};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h7 && byte_ff == 4'h0) begin
                    rw_ff  <= sda;
                    far_ff <= (sh_ff != `LHB_I2C_ADDR);
                end
            end else if (ack_end) begin
                bit_ff  <= 4'h0;
                byte_ff <= byte_ff + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_slave_ack_byte : assert property (
        ack_end && !far_ff && (byte_ff == 4'h0 || !rw_ff) |-> dev_sda_oe)
        else $error("received byte not acknowledged");
    a_read_end_free : assert property (
        ack_end && byte_ff != 4'h0 && rw_ff |-> !dev_sda_oe)
        else $error("data line held on read acknowledge");
    a_foreign_quiet : assert property (
        far_ff |-> !dev_sda_oe)
        else $error("device answered a foreign address");
    a_sda_hold_high : assert property (
        scl && scl_ff |-> $stable(dev_sda_oe))
        else $error("device moved data line with clock high");
    a_no_stretch : assert property (
        !host_scl_oe |-> scl)
        else $error("serial clock held low by device");
    a_dev_pin_shape : assert property (
        dev_db_oe == 8'h00 || dev_db_oe == 8'hf0 || dev_db_oe == 8'hff)
        else $error("device drives a partial data bus");
    a_host_pin_shape : assert property (
        host_db_oe == 8'h00 || host_db_oe == 8'hf0 || host_db_oe == 8'hff)
        else $error("host drives a partial data bus");
    a_strobe_steady : assert property (
        e && $past(e) |-> $stable({rs, rw, host_db_o & host_db_oe}))
        else $error("control or data moved during strobe");
endmodule

// ### lcd_host_bus_interface_tb_top.sv
// Testbench joining host and display controller ends
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module lcd_host_bus_interface_tb_top;
    import lhb_pkg::*;
    logic       clk         = 1'b0;
    logic       rst_n       = 1'b0;
    logic       req         = 1'b0;
    logic       ser         = 1'b0;
    logic       rd          = 1'b0;
    logic       sel         = 1'b0;
    logic       nib         = 1'b0;
    logic [7:0] wdata       = 8'h00;
    logic [7:0] status_byte = 8'h00;
    logic [7:0] read_byte   = 8'h00;
    logic       ready, done, nak, rx_valid, rx_sel, rd_done, nibble_mode;
    logic [7:0] rdata, rx_byte;
    int         err_count   = 0;
    int         compares    = 0;
    int         cycles      = 0;
    int         rx_cnt      = 0;
    int         rd_cnt      = 0;

    ////////////////////////////////////////////////////////////////////////
    lhb_if lhb_if_i ();
    lhb_host lhb_host_i (.clk(clk), .rst_n(rst_n), .bus(lhb_if_i.host), .req(req),
        .ser(ser), .rd(rd), .sel(sel), .nib(nib), .wdata(wdata), .ready(ready),
        .done(done), .rdata(rdata), .nak(nak));
    lhb_device lhb_device_i (.bus(lhb_if_i.dev), .rst_n(rst_n),
        .status_byte(status_byte), .read_byte(read_byte), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_sel(rx_sel), .rd_done(rd_done),
        .nibble_mode(nibble_mode));
    lhb_link_properties lhb_link_properties_i (.clk(clk), .rst_n(rst_n),
        .e(lhb_if_i.e), .rs(lhb_if_i.rs), .rw(lhb_if_i.rw),
        .host_db_o(lhb_if_i.host_db_o), .host_db_oe(lhb_if_i.host_db_oe),
        .dev_db_oe(lhb_if_i.dev_db_oe), .host_scl_oe(lhb_if_i.host_scl_oe),
        .dev_sda_oe(lhb_if_i.dev_sda_oe), .scl(lhb_if_i.scl), .sda(lhb_if_i.sda));

    // Clock
    always #12.5 clk = ~clk;

    // Device pulse counters, sampled mid link period
    always @(negedge lhb_if_i.link_clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
        if (rd_done === 1'b1) rd_cnt++;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One host transfer, request held over one taking edge
    task automatic xfer(input logic s, input logic r, input logic se, input logic [7:0] wd);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        ser   = s;
        rd    = r;
        sel   = se;
        wdata = wd;
        req   = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK("done", 1'b1, done)
        `CHK("ready", 1'b1, ready)
    endtask

    // Bounded wait for a device pulse count, then let outputs settle
    task automatic wait_cnt(input int want, input bit isrd);
        int n;
        n = 0;
        while ((isrd ? rd_cnt : rx_cnt) != want && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge lhb_if_i.link_clk);
        // Back onto the falling clk edge before any new stimulus
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_byte_mode();
        int base;
        base = rx_cnt;
        xfer(1'b0, 1'b0, 1'b0, 8'h38);
        wait_cnt(base + 1, 1'b0);
        `CHK("rx_byte", 8'h38, rx_byte)
        `CHK("rx_sel", 1'b0, rx_sel)
        `CHK("nibble_mode", 1'b0, nibble_mode)
        xfer(1'b0, 1'b0, 1'b1, 8'ha5);
        wait_cnt(base + 2, 1'b0);
        `CHK("rx_byte", 8'ha5, rx_byte)
        `CHK("rx_sel", 1'b1, rx_sel)
        read_byte   = 8'h5a;
        status_byte = 8'hc3;
        xfer(1'b0, 1'b1, 1'b1, 8'h00);
        `CHK("rdata", 8'h5a, rdata)
        xfer(1'b0, 1'b1, 1'b0, 8'h00);
        `CHK("rdata", 8'hc3, rdata)
    endtask

    task automatic t_nibble_mode();
        int base;
        int rbase;
        base = rx_cnt;
        xfer(1'b0, 1'b0, 1'b0, 8'h28);
        wait_cnt(base + 1, 1'b0);
        `CHK("nibble_mode", 1'b1, nibble_mode)
        nib = 1'b1;
        xfer(1'b0, 1'b0, 1'b1, 8'h96);
        wait_cnt(base + 2, 1'b0);
        `CHK("rx_count", base + 2, rx_cnt)
        `CHK("rx_byte", 8'h96, rx_byte)
        status_byte = 8'ha7;
        rbase = rd_cnt;
        xfer(1'b0, 1'b1, 1'b0, 8'h00);
        `CHK("rdata", 8'ha7, rdata)
        wait_cnt(rbase + 1, 1'b1);
        `CHK("rd_count", rbase + 1, rd_cnt)
        xfer(1'b0, 1'b0, 1'b0, 8'h38);
        wait_cnt(base + 3, 1'b0);
        nib = 1'b0;
        `CHK("nibble_mode", 1'b0, nibble_mode)
    endtask

    task automatic t_serial();
        int base;
        int rbase;
        base = rx_cnt;
        xfer(1'b1, 1'b0, 1'b0, 8'h0c);
        wait_cnt(base + 1, 1'b0);
        `CHK("rx_byte", 8'h0c, rx_byte)
        `CHK("rx_sel", 1'b0, rx_sel)
        `CHK("nak", 1'b0, nak)
        xfer(1'b1, 1'b0, 1'b1, 8'hf1);
        wait_cnt(base + 2, 1'b0);
        `CHK("rx_byte", 8'hf1, rx_byte)
        `CHK("rx_sel", 1'b1, rx_sel)
        read_byte = 8'h6c;
        rbase = rd_cnt;
        xfer(1'b1, 1'b1, 1'b1, 8'h00);
        `CHK("rdata", 8'h6c, rdata)
        `CHK("nak", 1'b0, nak)
        wait_cnt(rbase + 1, 1'b1);
        `CHK("rd_count", rbase + 1, rd_cnt)
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_byte_mode();
        t_nibble_mode();
        t_serial();
        summarize();
    end
endmodule
